// ==== hdl/memory_address_decoder.sv ====
// Address decoder of the core bus with the local port registers.
// Assumes the core presents address and strobes for one clock per access
// and that the selected memories answer the forwarded request themselves.
`timescale 1ns/1ps
module memory_address_decoder import addr_decode_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input cpu_req_s cpu,
  output logic [7:0] cpu_rdata,
  output mem_req_s mem_req,
  output logic illegal_reset_req,
  input wire logic [6:0] pta_in,
  output logic [6:0] pta_out,
  output logic [6:0] pta_oe_n,
  output logic [6:0] ptb_out,
  output logic [1:0] ptc_out,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ****************************************************************
  // Decode of the core access.
  // ****************************************************************
  logic access;
  region_e region;

  assign access = cpu.rd || cpu.wr;

  addr_region_map u_map (
    .addr(cpu.addr),
    .wr(cpu.wr),
    .region(region)
  );

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic reg_wr_en;
  logic [5:0] reg_wr_idx;
  logic [7:0] reg_wr_data;
  logic reg_wr_err;
  logic [5:0] reg_rd_idx;
  logic [31:0] reg_rd_data;
  logic reg_rd_err;

  axil_reg_slave u_bus (
    .mclk(mclk),
    .rst_n(rst_n),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(reg_wr_en),
    .wr_idx(reg_wr_idx),
    .wr_data(reg_wr_data),
    .wr_err(reg_wr_err),
    .rd_idx(reg_rd_idx),
    .rd_data(reg_rd_data),
    .rd_err(reg_rd_err)
  );

  // ****************************************************************
  // Port registers.
  // ****************************************************************
  logic [7:0] port_a;
  logic [7:0] port_b;
  logic [7:0] port_c;
  logic [7:0] dir_a;
  logic [15:0] illegal_count;
  logic [15:0] last_illegal_addr;
  logic [7:0] bus_idx_wr;
  logic [7:0] bus_idx_rd;
  logic w_en;
  logic [7:0] w_idx;
  logic [7:0] w_data;
  logic status_clear;
  logic illegal_hit;

  assign bus_idx_wr = {2'b00, reg_wr_idx};
  assign bus_idx_rd = {2'b00, reg_rd_idx};
  assign illegal_hit = access && (region == R_UNIMPL);

  function automatic logic is_port(input logic [7:0] idx);
    is_port = (idx == PORT_A_IDX) || (idx == PORT_B_IDX) ||
              (idx == PORT_C_IDX) || (idx == DIR_A_IDX);
  endfunction : is_port

  // Reads only select a value; no register moves on a read.
  function automatic logic [7:0] port_read(input logic [7:0] idx);
    logic [7:0] pins;
    pins = {1'b0, pta_in};
    port_read = 8'h00;
    if (idx == PORT_A_IDX) begin
      port_read = ((port_a & dir_a) | (pins & ~dir_a)) & PORT_AB_MASK;
    end else if (idx == PORT_B_IDX) begin
      port_read = port_b & PORT_AB_MASK;
    end else if (idx == PORT_C_IDX) begin
      port_read = port_c & PORT_C_MASK;
    end else if (idx == DIR_A_IDX) begin
      port_read = dir_a & PORT_AB_MASK;
    end
  endfunction : port_read

  assign reg_wr_err = !is_port(bus_idx_wr) && (bus_idx_wr != STATUS_IDX);
  assign reg_rd_err = !is_port(bus_idx_rd) && (bus_idx_rd != STATUS_IDX);
  assign reg_rd_data = (bus_idx_rd == STATUS_IDX) ?
                       {illegal_count, last_illegal_addr} :
                       {24'h000000, port_read(bus_idx_rd)};
  assign status_clear = reg_wr_en && (bus_idx_wr == STATUS_IDX);

  // The core wins a same-cycle collision; the bus write is then lost.
  always_comb begin
    w_en = 1'b0;
    w_idx = 8'h00;
    w_data = 8'h00;
    if (cpu.wr && (region == R_PORT)) begin
      w_en = 1'b1;
      w_idx = cpu.addr[7:0];
      w_data = cpu.wdata;
    end else if (reg_wr_en && is_port(bus_idx_wr)) begin
      w_en = 1'b1;
      w_idx = bus_idx_wr;
      w_data = reg_wr_data;
    end
  end

  // Data latches have no reset so their contents survive it.
  always_ff @(posedge mclk) begin
    if (w_en && (w_idx == PORT_A_IDX)) port_a <= w_data & PORT_AB_MASK;
    if (w_en && (w_idx == PORT_B_IDX)) port_b <= w_data & PORT_AB_MASK;
    if (w_en && (w_idx == PORT_C_IDX)) port_c <= w_data & PORT_C_MASK;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dir_a <= DIR_A_RESET;
    end else if (w_en && (w_idx == DIR_A_IDX)) begin
      dir_a <= w_data & PORT_AB_MASK;
    end
  end

  // ****************************************************************
  // Pin drive.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pta_out <= '0;
      pta_oe_n <= '1;
      ptb_out <= '0;
      ptc_out <= '0;
    end else begin
      pta_out <= port_a[6:0];
      pta_oe_n <= ~dir_a[6:0];
      ptb_out <= port_b[6:0];
      ptc_out <= port_c[1:0];
    end
  end

  // ****************************************************************
  // Forwarded request, read data and illegal-address reset.
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req.region <= access ? region : R_IDLE;
      mem_req.addr <= cpu.addr;
      mem_req.rd <= cpu.rd;
      mem_req.wr <= cpu.wr;
      mem_req.wdata <= cpu.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpu_rdata <= 8'h00;
    end else if (cpu.rd && (region == R_PORT)) begin
      cpu_rdata <= port_read(cpu.addr[7:0]);
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      illegal_reset_req <= 1'b0;
    end else begin
      illegal_reset_req <= illegal_hit;
    end
  end

  // A clear in the same cycle as a new event restarts the count at one.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      illegal_count <= '0;
      last_illegal_addr <= '0;
    end else if (illegal_hit) begin
      last_illegal_addr <= cpu.addr;
      if (status_clear) illegal_count <= 16'h0001;
      else if (illegal_count != COUNT_MAX)
        illegal_count <= illegal_count + 16'h0001;
    end else if (status_clear) begin
      illegal_count <= '0;
    end
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_one_region;
    access |=> (mem_req.region != R_IDLE) && (mem_req.rd == $past(cpu.rd));
  endproperty
  a_one_region: assert property (p_one_region)
    else $error("access not forwarded with one region");

  property p_unimpl_pulse;
    illegal_hit |=> illegal_reset_req;
  endproperty
  a_unimpl_pulse: assert property (p_unimpl_pulse)
    else $error("unimplemented access gave no reset request");

  property p_pulse_cause;
    illegal_reset_req |-> $past(access) && ($past(region) == R_UNIMPL);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("reset request without an illegal access");

  property p_ro_write;
    cpu.wr && (region == R_PORT) |=> !illegal_reset_req;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("port write raised an illegal reset");

  property p_io_page;
    access && (cpu.addr > PORT_LAST) && (cpu.addr <= IO_END)
      |=> mem_req.region == R_IO;
  endproperty
  a_io_page: assert property (p_io_page)
    else $error("I/O page not selected");

  property p_ram;
    access && (cpu.addr >= RAM_BASE) && (cpu.addr <= RAM_END)
      |=> mem_req.region == R_RAM;
  endproperty
  a_ram: assert property (p_ram)
    else $error("RAM not selected");

  property p_big_gap;
    access && (cpu.addr > RAM_END) && (cpu.addr < FLASH_BASE)
      |=> illegal_reset_req ##1 !illegal_reset_req || $past(illegal_hit);
  endproperty
  a_big_gap: assert property (p_big_gap)
    else $error("gap access gave no reset request");

  property p_flash;
    access && (cpu.addr >= FLASH_BASE) && (cpu.addr <= FLASH_END)
      |=> (mem_req.region == R_FLASH) && !illegal_reset_req;
  endproperty
  a_flash: assert property (p_flash)
    else $error("flash not selected");

  property p_rom;
    access && (cpu.addr >= ROM_BASE) && (cpu.addr <= ROM_END)
      |=> mem_req.region == R_ROM;
  endproperty
  a_rom: assert property (p_rom)
    else $error("monitor ROM not selected");

  property p_rom_gap;
    access && (cpu.addr > ROM_END) && (cpu.addr <= ROM_GAP_END)
      |=> illegal_reset_req;
  endproperty
  a_rom_gap: assert property (p_rom_gap)
    else $error("ROM gap access gave no reset request");

  property p_fprot;
    access && (cpu.addr == FPROT_ADDR) |=> mem_req.region == R_FPROT;
  endproperty
  a_fprot: assert property (p_fprot)
    else $error("flash protect not selected");

  property p_vector;
    access && (cpu.addr >= VECT_BASE) && (cpu.addr < TOP_ADDR)
      |=> mem_req.region == R_VECT;
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector area not selected");

  property p_top_byte;
    access && (cpu.addr == TOP_ADDR)
      |=> mem_req.region == ($past(cpu.wr) ? R_WDOG : R_VECT);
  endproperty
  a_top_byte: assert property (p_top_byte)
    else $error("top byte routed wrongly");

  property p_sys_holes;
    access && ((cpu.addr == 16'hFE09) || (cpu.addr == 16'hFE0B))
      |=> illegal_reset_req;
  endproperty
  a_sys_holes: assert property (p_sys_holes)
    else $error("system page hole gave no reset request");

  property p_io_hole;
    access && (cpu.addr == IO_HOLE) |=> illegal_reset_req;
  endproperty
  a_io_hole: assert property (p_io_hole)
    else $error("I/O hole gave no reset request");

  property p_port_c_bits;
    w_en && (w_idx == PORT_C_IDX) |=> (port_c[7:2] == 6'h00);
  endproperty
  a_port_c_bits: assert property (p_port_c_bits)
    else $error("port C upper bits were stored");

  property p_dir_reset;
    $rose(rst_n) |-> (dir_a == DIR_A_RESET) && pta_oe_n == 7'h7F;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("direction not cleared by reset");

endmodule : memory_address_decoder

// ==== hdl/addr_decode_pkg.sv ====
// Constants, types and the address map of the memory address decoder.
// Assumes one core bus clock and a synchronous active-low system reset.
package addr_decode_pkg;

  // ****************************************************************
  // Address map of the core bus.
  // ****************************************************************
  localparam logic [15:0] IO_END = 16'h005F;
  localparam logic [15:0] IO_HOLE = 16'h0003;
  localparam logic [15:0] PORT_LAST = 16'h0004;
  localparam logic [15:0] RAM_BASE = 16'h0060;
  localparam logic [15:0] RAM_END = 16'h015F;
  localparam logic [15:0] GAP_END = 16'hDFFF;
  localparam logic [15:0] FLASH_BASE = 16'hE000;
  localparam logic [15:0] FLASH_END = 16'hFDFF;
  localparam logic [15:0] SYS_BASE = 16'hFE00;
  localparam logic [15:0] SYS_END = 16'hFE0F;
  localparam logic [15:0] ROM_BASE = 16'hFE10;
  localparam logic [15:0] ROM_END = 16'hFF48;
  localparam logic [15:0] ROM_GAP_END = 16'hFF7D;
  localparam logic [15:0] FPROT_ADDR = 16'hFF7E;
  localparam logic [15:0] FPROT_GAP_END = 16'hFFD1;
  localparam logic [15:0] VECT_BASE = 16'hFFD2;
  localparam logic [15:0] TOP_ADDR = 16'hFFFF;

  // ****************************************************************
  // Local port registers: index on both buses (status on the register bus only), masks, reset values.
  // ****************************************************************
  localparam logic [7:0] PORT_A_IDX = 8'h00;
  localparam logic [7:0] PORT_B_IDX = 8'h01;
  localparam logic [7:0] PORT_C_IDX = 8'h02;
  localparam logic [7:0] DIR_A_IDX = 8'h04;
  localparam logic [7:0] STATUS_IDX = 8'h10;
  localparam logic [7:0] PORT_AB_MASK = 8'h7F;
  localparam logic [7:0] PORT_C_MASK = 8'h03;
  localparam logic [7:0] DIR_A_RESET = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    R_IDLE, R_IO, R_PORT, R_RAM, R_FLASH, R_SYS, R_ROM, R_FPROT,
    R_VECT, R_WDOG, R_RSVD, R_UNIMPL
  } region_e;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cpu_req_s;

  typedef struct packed {
    region_e region;
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mem_req_s;

endpackage : addr_decode_pkg

// ==== hdl/addr_region_map.sv ====
// Combinational map from a core address to the region it selects.
// Assumes the address is stable for the whole bus cycle.
`timescale 1ns/1ps
module addr_region_map import addr_decode_pkg::*; (
  input wire logic [15:0] addr,
  input wire logic wr,
  output region_e region
);

  always_comb begin
    region = R_UNIMPL;
    if (addr <= IO_END) begin
      if (addr == IO_HOLE) region = R_UNIMPL;
      else if (addr <= PORT_LAST) region = R_PORT;
      else region = R_IO;
    end else if (addr <= RAM_END) begin
      region = R_RAM;
    end else if (addr <= GAP_END) begin
      region = R_UNIMPL;
    end else if (addr <= FLASH_END) begin
      region = R_FLASH;
    end else if (addr <= SYS_END) begin
      unique case (addr[3:0])
        4'h9, 4'hB: region = R_UNIMPL;
        4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'hA: region = R_RSVD;
        default: region = R_SYS;
      endcase
    end else if (addr <= ROM_END) begin
      region = R_ROM;
    end else if (addr <= ROM_GAP_END) begin
      region = R_UNIMPL;
    end else if (addr == FPROT_ADDR) begin
      region = R_FPROT;
    end else if (addr <= FPROT_GAP_END) begin
      region = R_UNIMPL;
    end else if (addr == TOP_ADDR) begin
      region = wr ? R_WDOG : R_VECT;
    end else begin
      region = R_VECT;
    end
  end

endmodule : addr_region_map

// ==== hdl/axil_reg_slave.sv ====
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the master keeps one write and one read under way at most.
`timescale 1ns/1ps
module axil_reg_slave import addr_decode_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [5:0] wr_idx,
  output logic [7:0] wr_data,
  input wire logic wr_err,
  output logic [5:0] rd_idx,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  logic wr_lane;
  logic wr_issue;
  logic rd_issue;

  // A write issues once address and data are both held.
  assign wr_issue = !awready && !wready && !bvalid;
  assign wr_en = wr_issue && wr_lane;
  assign rd_issue = !arready && !rvalid;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wr_idx <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      wr_idx <= awaddr[7:2];
    end else if (wr_issue) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wready <= 1'b1;
      wr_data <= '0;
      wr_lane <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      wr_data <= wdata[7:0];
      wr_lane <= wstrb[0];
    end else if (wr_issue) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_issue) begin
      bvalid <= 1'b1;
      bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rd_idx <= '0;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rd_idx <= araddr[7:2];
    end else if (rvalid && rready) begin
      arready <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_issue) begin
      rvalid <= 1'b1;
      rdata <= rd_err ? '0 : rd_data;
      rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : axil_reg_slave

// ==== dv/core_model.sv ====
// Model of the processor core that issues byte accesses to the decoder.
// Assumes the bench hands it one request per cycle on req_valid.
`timescale 1ns/1ps
module core_model import addr_decode_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic [15:0] req_addr,
  input wire logic req_wr,
  input wire logic [7:0] req_wdata,
  output cpu_req_s cpu
);
  logic rsvd;
  // ****************************************************************
  // Request launch.
  // ****************************************************************
  assign rsvd = req_addr == 16'hFE02 || req_addr == 16'hFE0A ||
    (req_addr >= 16'hFE04 && req_addr <= 16'hFE07);
  // Software never stores into reserved places, so such a write is
  // dropped here. Idle cycles toggle the address bus.
  always_ff @(posedge mclk) begin
    if (!rst_n || !req_valid) begin
      cpu.addr <= ~cpu.addr;
      cpu.rd <= 1'b0;
      cpu.wr <= 1'b0;
      cpu.wdata <= ~cpu.wdata;
    end else begin
      cpu.addr <= req_addr;
      cpu.rd <= !req_wr;
      cpu.wr <= req_wr && !rsvd;
      cpu.wdata <= req_wdata;
    end
  end
endmodule : core_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the memory address decoder.
// Assumes the core model on the core bus and an AXI4-Lite master here.
`timescale 1ns/1ps
module tb_top import addr_decode_pkg::*;;
  logic mclk, rst_n, req_valid, req_wr, got_ill;
  logic [15:0] req_addr;
  logic [7:0] req_wdata, cpu_rdata, got_rd, awaddr, araddr;
  cpu_req_s cpu;
  mem_req_s mem_req;
  region_e got_reg;
  logic illegal_reset_req, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready;
  logic [6:0] pta_in, pta_out, pta_oe_n, ptb_out;
  logic [1:0] ptc_out, bresp, rresp, resp;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  int num_errors, tests_run, cyc;
  localparam int NC = 27;
  localparam logic [15:0] TA [NC] = '{16'h0000, 16'h0003, 16'h0005,
    16'h005F, 16'h0060, 16'h015F, 16'h0160, 16'hDFFF, 16'hE000,
    16'hFDFF, 16'hFE00, 16'hFE02, 16'hFE09, 16'hFE0A, 16'hFE0B,
    16'hFE0F, 16'hFE10, 16'hFF48, 16'hFF49, 16'hFF7D, 16'hFF7E,
    16'hFF7F, 16'hFFD1, 16'hFFD2, 16'hFFFE, 16'hFFFF, 16'hFFFF};
  localparam region_e TR [NC] = '{R_PORT, R_UNIMPL, R_IO, R_IO, R_RAM,
    R_RAM, R_UNIMPL, R_UNIMPL, R_FLASH, R_FLASH, R_SYS, R_RSVD,
    R_UNIMPL, R_RSVD, R_UNIMPL, R_SYS, R_ROM, R_ROM, R_UNIMPL, R_UNIMPL,
    R_FPROT, R_UNIMPL, R_UNIMPL, R_VECT, R_VECT, R_VECT, R_WDOG};

  core_model core_u (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
    .req_addr(req_addr), .req_wr(req_wr), .req_wdata(req_wdata),
    .cpu(cpu));
  memory_address_decoder dut_u (.mclk(mclk), .rst_n(rst_n), .cpu(cpu),
    .cpu_rdata(cpu_rdata), .mem_req(mem_req),
    .illegal_reset_req(illegal_reset_req), .pta_in(pta_in),
    .pta_out(pta_out), .pta_oe_n(pta_oe_n), .ptb_out(ptb_out),
    .ptc_out(ptc_out), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ****************************************************************
  // Clock, timeout and shared tasks.
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic check(input logic [31:0] seen, exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, m, seen, exp);
    end
  endtask : check
  // One core access; outputs are captured the cycle after it is taken.
  task automatic core(input logic [15:0] a, input logic w,
                      input logic [7:0] d);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_addr <= a;
    req_wr <= w;
    req_wdata <= d;
    @(posedge mclk);
    req_valid <= 1'b0;
    @(posedge mclk);
    #1;
    got_reg = mem_req.region;
    got_ill = illegal_reset_req;
    got_rd = cpu_rdata;
    @(posedge mclk);
    #1;
  endtask : core
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge mclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_map();
    for (int i = 0; i < NC; i++) begin
      core(TA[i], i == NC - 1, 8'h00);
      check({28'h0, got_reg}, {28'h0, TR[i]}, "region");
      check(got_ill, TR[i] == R_UNIMPL, "illegal");
      check(illegal_reset_req, 1'b0, "pulse");
    end
    axi_rd(STATUS_IDX * 4);
    check(rd[15:0], 16'hFFD1, "last illegal");
  endtask : t_map
  task automatic t_ports();
    core(16'h0002, 1'b1, 8'hFF);
    check(got_ill, 1'b0, "ro write");
    check(ptc_out, 2'h3, "port c out");
    core(16'h0002, 1'b0, 8'h00);
    check(got_rd, 8'h03, "port c read");
    core(16'h0001, 1'b1, 8'hFF);
    check(ptb_out, 7'h7F, "port b out");
    axi_rd(PORT_B_IDX * 4);
    check(rd, 32'h7F, "port b bus");
    axi_wr(DIR_A_IDX * 4, 32'h7F);
    check(resp, RESP_OKAY, "dir resp");
    core(16'h0000, 1'b1, 8'hAA);
    check(pta_oe_n, 7'h00, "dir out");
    check(pta_out, 7'h2A, "port a out");
    core(16'h0000, 1'b0, 8'h00);
    check(got_rd, 8'h2A, "port a read");
    axi_wr(8'h0C, 32'h1);
    check(resp, RESP_SLVERR, "unmapped write");
    axi_rd(8'h0C);
    check(resp, RESP_SLVERR, "unmapped read");
  endtask : t_ports
  task automatic t_reset();
    core(16'h0001, 1'b1, 8'h55);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check(ptb_out, 7'h55, "kept data");
    check(pta_oe_n, 7'h7F, "dir reset");
    axi_rd(DIR_A_IDX * 4);
    check(rd, {24'h0, DIR_A_RESET}, "dir read");
  endtask : t_reset

  initial begin
    {rst_n, req_valid, req_wr, awvalid, wvalid, bready} = '0;
    {arvalid, rready, req_addr, req_wdata, awaddr, araddr} = '0;
    {wdata, wstrb, num_errors, tests_run, cyc} = '0;
    pta_in = 7'h55;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    t_map();
    t_ports();
    t_reset();
    results();
  end
endmodule : tb_top
